// file: logic/cfg_regs_pkg.sv
// Purpose: Constants for the two converter configuration registers
// Assumes: 8-bit registers, register command port as documented
// Notes: Addresses, field positions, reset values, field codes and modulator rates
package cfg_regs_pkg;
  localparam logic [1:0] ADDR_INPUT_GAIN = 2'h0;
  localparam logic [1:0] ADDR_RATE_MODE = 2'h1;
  localparam logic [7:0] RESET_INPUT_GAIN = 8'h00;
  localparam logic [7:0] RESET_RATE_MODE = 8'h00;
  // Register zero fields
  localparam int INPUT_SELECT_LSB = 4;
  localparam int GAIN_LSB = 1;
  localparam int AMP_BYPASS_POS = 0;
  // Register one fields
  localparam int RATE_SELECT_LSB = 5;
  localparam int OP_MODE_POS = 4;
  localparam int CONV_MODE_POS = 3;
  localparam int REF_SELECT_LSB = 1;
  localparam int TEMP_SENSOR_POS = 0;
  localparam logic [2:0] GAIN_CODE_8 = 3'h3;
  localparam logic [2:0] RATE_RESERVED = 3'h7;
  localparam logic [3:0] INPUT_SELECT_DEFAULT = 4'h0;
  // Modulator clock rates in kHz
  localparam int MOD_KHZ_NORMAL = 256;
  localparam int MOD_KHZ_TURBO = 512;
  typedef enum logic [1:0]
  {
    REF_INTERNAL = 2'b00,
    REF_EXTERNAL = 2'b01,
    REF_SUPPLY = 2'b10
  } ref_src_e;
endpackage : cfg_regs_pkg

// file: logic/cfg_field_if.sv
// Purpose: Raw register fields passed to the effective-setting decoder
// Assumes: Single clock
// Notes: Carrier between the register bank and decoder
`timescale 1ns/1ps
interface cfg_field_if;
  logic [7:0] input_gain;
  logic [7:0] rate_mode;
  modport bank (output input_gain, output rate_mode);
  modport dec (input input_gain, input rate_mode);
endinterface : cfg_field_if

// file: logic/cfg_effective_decode.sv
// Purpose: Turns raw register fields into effective analog controls
// Assumes: Fields held in flip-flops upstream
// Notes: Purely combinational
`timescale 1ns/1ps
module cfg_effective_decode
(
  // Raw fields
  cfg_field_if.dec fields,
  // Effective controls
  output logic [3:0] input_select_field_out,
  output logic [2:0] gain_out,
  output logic amp_enable_out,
  output logic [2:0] rate_select_field_out,
  output logic turbo_out,
  output logic [9:0] mod_clock_khz_out,
  output logic continuous_out,
  output cfg_regs_pkg::ref_src_e ref_src_out,
  output logic temp_mode_out
);
  wire [3:0] raw_mux = fields.input_gain[cfg_regs_pkg::INPUT_SELECT_LSB +: 4];
  wire [2:0] raw_gain = fields.input_gain[cfg_regs_pkg::GAIN_LSB +: 3];
  wire raw_bypass = fields.input_gain[cfg_regs_pkg::AMP_BYPASS_POS];
  wire [1:0] raw_ref = fields.rate_mode[cfg_regs_pkg::REF_SELECT_LSB +: 2];
  wire temp = fields.rate_mode[cfg_regs_pkg::TEMP_SENSOR_POS];
  wire high_gain = raw_gain >= cfg_regs_pkg::GAIN_CODE_8;
  wire turbo = fields.rate_mode[cfg_regs_pkg::OP_MODE_POS];

  // Temperature mode masks register zero entirely
  assign temp_mode_out = temp;
  assign input_select_field_out = temp ? cfg_regs_pkg::INPUT_SELECT_DEFAULT : raw_mux;
  assign gain_out = temp ? 3'h0 : raw_gain;
  // Bypass only honoured below gain 8
  assign amp_enable_out = temp | high_gain | ~raw_bypass;
  // Rate code meaning depends on turbo; downstream pairs both
  assign rate_select_field_out = fields.rate_mode[cfg_regs_pkg::RATE_SELECT_LSB +: 3];
  assign turbo_out = turbo;
  assign mod_clock_khz_out = turbo ? 10'(cfg_regs_pkg::MOD_KHZ_TURBO)
                                   : 10'(cfg_regs_pkg::MOD_KHZ_NORMAL);
  assign continuous_out = fields.rate_mode[cfg_regs_pkg::CONV_MODE_POS];
  assign ref_src_out = temp ? cfg_regs_pkg::REF_INTERNAL
                     : (raw_ref[1] ? cfg_regs_pkg::REF_SUPPLY
                     : (raw_ref[0] ? cfg_regs_pkg::REF_EXTERNAL : cfg_regs_pkg::REF_INTERNAL));
endmodule : cfg_effective_decode

// file: logic/adc_config_regs_zero_one.sv
// Purpose: Configuration registers zero and one of a delta-sigma converter
// Assumes: Serial-bus engine decodes register read and write commands upstream
// Notes: Power-down does not touch the stored values
// Function
// - Register zero at address zero, resets zero
// - Register one at address one, resets zero
// - Amplifier stays enabled for gain eight up
// - Rate code meaning depends on operating mode
// - Modulator 256 kHz normal, 512 kHz turbo
// - Conversion mode bit: single-shot or continuous
// - Reference field picks internal, external, supply
// - Temperature bit enables sensor measurement mode
// - Temperature mode ignores register zero settings
// - Temperature mode forces internal reference
// - Host accesses registers by read/write commands
// - Values retained during power-down
`timescale 1ns/1ps
module adc_config_regs_zero_one
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register command port from serial-bus engine
  input wire logic register_write_command_in,
  input wire logic register_read_command_in,
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Power state
  input wire logic power_down_in,
  // Effective analog controls
  output logic [3:0] input_select_field_out,
  output logic [2:0] gain_out,
  output logic amp_enable_out,
  output logic [2:0] rate_select_field_out,
  output logic turbo_out,
  output logic [9:0] mod_clock_khz_out,
  output logic continuous_out,
  output cfg_regs_pkg::ref_src_e ref_src_out,
  output logic temp_mode_out
);
  cfg_field_if fields();
  logic [7:0] input_gain_config;
  logic [7:0] rate_mode_config;
  logic [7:0] next_rd_data;

  // Shared by the write enables and the read select
  function automatic logic addr_match(input logic [1:0] addr, input logic [1:0] target);
    return addr == target;
  endfunction : addr_match

  wire hit_zero = addr_match(reg_addr_in, cfg_regs_pkg::ADDR_INPUT_GAIN);
  wire hit_one = addr_match(reg_addr_in, cfg_regs_pkg::ADDR_RATE_MODE);
  // Power-down gates nothing here, so contents survive it
  wire wr_zero = register_write_command_in & hit_zero;
  wire wr_one = register_write_command_in & hit_one;
  // Unmapped addresses read as zero
  assign next_rd_data = hit_zero ? input_gain_config
                      : (hit_one ? rate_mode_config : 8'h00);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      input_gain_config <= cfg_regs_pkg::RESET_INPUT_GAIN;
    else if (wr_zero)
      input_gain_config <= wr_data_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rate_mode_config <= cfg_regs_pkg::RESET_RATE_MODE;
    else if (wr_one)
      rate_mode_config <= wr_data_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= register_read_command_in;
      if (register_read_command_in)
        rd_data_out <= next_rd_data;
    end
  end

  assign fields.input_gain = input_gain_config;
  assign fields.rate_mode = rate_mode_config;

  cfg_effective_decode u_decode
  (
    .fields(fields.dec),
    .input_select_field_out(input_select_field_out),
    .gain_out(gain_out),
    .amp_enable_out(amp_enable_out),
    .rate_select_field_out(rate_select_field_out),
    .turbo_out(turbo_out),
    .mod_clock_khz_out(mod_clock_khz_out),
    .continuous_out(continuous_out),
    .ref_src_out(ref_src_out),
    .temp_mode_out(temp_mode_out)
  );

  property p_reset_zero;
    @(posedge clk_in) srst_in |=> (input_gain_config == 8'h00 && rate_mode_config == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("Registers not cleared by reset");

  property p_write_one;
    @(posedge clk_in) disable iff (srst_in)
      (register_write_command_in && reg_addr_in == 2'h1) |=> rate_mode_config == $past(wr_data_in);
  endproperty
  a_write_one: assert property (p_write_one) else $error("Register one write lost");

  property p_amp_high_gain;
    @(posedge clk_in) disable iff (srst_in)
      (!temp_mode_out && input_gain_config[3:1] >= 3'h3) |-> amp_enable_out;
  endproperty
  a_amp_high_gain: assert property (p_amp_high_gain) else $error("Amplifier bypassed at high gain");

  property p_bypass_low_gain;
    @(posedge clk_in) disable iff (srst_in)
      (!temp_mode_out && input_gain_config[3:1] < 3'h3 && input_gain_config[0]) |-> !amp_enable_out;
  endproperty
  a_bypass_low_gain: assert property (p_bypass_low_gain) else $error("Bypass ignored at low gain");

  property p_mod_clock;
    @(posedge clk_in) disable iff (srst_in)
      mod_clock_khz_out == (rate_mode_config[4] ? 10'(cfg_regs_pkg::MOD_KHZ_TURBO) : 10'(cfg_regs_pkg::MOD_KHZ_NORMAL));
  endproperty
  a_mod_clock: assert property (p_mod_clock) else $error("Modulator clock wrong");

  property p_continuous;
    @(posedge clk_in) disable iff (srst_in)
      (register_write_command_in && reg_addr_in == 2'h1) |=> continuous_out == $past(wr_data_in[3]);
  endproperty
  a_continuous: assert property (p_continuous) else $error("Conversion mode not applied");

  property p_ref_supply;
    @(posedge clk_in) disable iff (srst_in)
      (!rate_mode_config[0] && rate_mode_config[2]) |-> ref_src_out == cfg_regs_pkg::REF_SUPPLY;
  endproperty
  a_ref_supply: assert property (p_ref_supply) else $error("Supply reference not chosen");

  property p_temp_ref;
    @(posedge clk_in) disable iff (srst_in)
      rate_mode_config[0] |-> (ref_src_out == cfg_regs_pkg::REF_INTERNAL && amp_enable_out && gain_out == 3'h0);
  endproperty
  a_temp_ref: assert property (p_temp_ref) else $error("Temperature mode settings wrong");

  property p_readback;
    @(posedge clk_in) disable iff (srst_in)
      (register_read_command_in && reg_addr_in == 2'h0) |=> (rd_valid_out && rd_data_out == $past(input_gain_config));
  endproperty
  a_readback: assert property (p_readback) else $error("Read data mismatch");

  property p_retain_pd;
    @(posedge clk_in) disable iff (srst_in)
      (power_down_in && !register_write_command_in) |=> $stable(input_gain_config) && $stable(rate_mode_config);
  endproperty
  a_retain_pd: assert property (p_retain_pd) else $error("Values changed in power-down");

  property p_reset_read;
    @(posedge clk_in)
      srst_in
      |=> (!rd_valid_out && rd_data_out == 8'h00);
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("Read port not cleared by reset");

  property p_reset_fields;
    @(posedge clk_in)
      srst_in
      |=> (amp_enable_out && ref_src_out == cfg_regs_pkg::REF_INTERNAL && !continuous_out && !temp_mode_out);
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("Controls not at defaults after reset");

  property p_write_zero;
    @(posedge clk_in) disable iff (srst_in)
      (register_write_command_in && reg_addr_in == 2'h0)
      |=> input_gain_config == $past(wr_data_in);
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("Register zero write lost");

  property p_write_zero_only;
    @(posedge clk_in) disable iff (srst_in)
      (register_write_command_in && reg_addr_in == 2'h0)
      |=> $stable(rate_mode_config);
  endproperty
  a_write_zero_only: assert property (p_write_zero_only) else $error("Register zero write hit register one");

  property p_write_one_only;
    @(posedge clk_in) disable iff (srst_in)
      (register_write_command_in && reg_addr_in == 2'h1)
      |=> $stable(input_gain_config);
  endproperty
  a_write_one_only: assert property (p_write_one_only) else $error("Register one write hit register zero");

  property p_unmapped_write;
    @(posedge clk_in) disable iff (srst_in)
      (register_write_command_in && reg_addr_in[1])
      |=> ($stable(input_gain_config) && $stable(rate_mode_config));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write changed a register");

  property p_idle_hold;
    @(posedge clk_in) disable iff (srst_in)
      !register_write_command_in
      |=> ($stable(input_gain_config) && $stable(rate_mode_config));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Register changed without a write");

  property p_read_one;
    @(posedge clk_in) disable iff (srst_in)
      (register_read_command_in && reg_addr_in == 2'h1)
      |=> (rd_valid_out && rd_data_out == $past(rate_mode_config));
  endproperty
  a_read_one: assert property (p_read_one) else $error("Register one read mismatch");

  property p_read_unmapped;
    @(posedge clk_in) disable iff (srst_in)
      (register_read_command_in && reg_addr_in[1])
      |=> (rd_valid_out && rd_data_out == 8'h00);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("Unmapped read not zero");

  property p_rd_valid_pulse;
    @(posedge clk_in) disable iff (srst_in)
      !register_read_command_in
      |=> !rd_valid_out;
  endproperty
  a_rd_valid_pulse: assert property (p_rd_valid_pulse) else $error("Read valid without a read");

  property p_rd_data_hold;
    @(posedge clk_in) disable iff (srst_in)
      !register_read_command_in
      |=> $stable(rd_data_out);
  endproperty
  a_rd_data_hold: assert property (p_rd_data_hold) else $error("Read data moved without a read");

  property p_rate_field;
    @(posedge clk_in) disable iff (srst_in)
      rate_select_field_out == rate_mode_config[7:5];
  endproperty
  a_rate_field: assert property (p_rate_field) else $error("Rate code not passed on");

  property p_turbo_bit;
    @(posedge clk_in) disable iff (srst_in)
      turbo_out == rate_mode_config[4];
  endproperty
  a_turbo_bit: assert property (p_turbo_bit) else $error("Operating mode not passed on");

  property p_cm_level;
    @(posedge clk_in) disable iff (srst_in)
      continuous_out == rate_mode_config[3];
  endproperty
  a_cm_level: assert property (p_cm_level) else $error("Conversion mode not passed on");

  property p_temp_bit;
    @(posedge clk_in) disable iff (srst_in)
      temp_mode_out == rate_mode_config[0];
  endproperty
  a_temp_bit: assert property (p_temp_bit) else $error("Temperature mode not passed on");

  property p_ref_internal;
    @(posedge clk_in) disable iff (srst_in)
      (!rate_mode_config[0] && rate_mode_config[2:1] == 2'h0)
      |-> ref_src_out == cfg_regs_pkg::REF_INTERNAL;
  endproperty
  a_ref_internal: assert property (p_ref_internal) else $error("Internal reference not chosen");

  property p_ref_external;
    @(posedge clk_in) disable iff (srst_in)
      (!rate_mode_config[0] && rate_mode_config[2:1] == 2'h1)
      |-> ref_src_out == cfg_regs_pkg::REF_EXTERNAL;
  endproperty
  a_ref_external: assert property (p_ref_external) else $error("External reference not chosen");

  property p_temp_mux;
    @(posedge clk_in) disable iff (srst_in)
      rate_mode_config[0]
      |-> input_select_field_out == 4'h0;
  endproperty
  a_temp_mux: assert property (p_temp_mux) else $error("Input select leaked in temperature mode");

  property p_temp_amp;
    @(posedge clk_in) disable iff (srst_in)
      rate_mode_config[0]
      |-> amp_enable_out;
  endproperty
  a_temp_amp: assert property (p_temp_amp) else $error("Bypass leaked in temperature mode");

  property p_mux_pass;
    @(posedge clk_in) disable iff (srst_in)
      !rate_mode_config[0]
      |-> input_select_field_out == input_gain_config[7:4];
  endproperty
  a_mux_pass: assert property (p_mux_pass) else $error("Input select not passed on");

  property p_gain_pass;
    @(posedge clk_in) disable iff (srst_in)
      !rate_mode_config[0]
      |-> gain_out == input_gain_config[3:1];
  endproperty
  a_gain_pass: assert property (p_gain_pass) else $error("Gain not passed on");

  property p_amp_no_bypass;
    @(posedge clk_in) disable iff (srst_in)
      (!rate_mode_config[0] && !input_gain_config[0])
      |-> amp_enable_out;
  endproperty
  a_amp_no_bypass: assert property (p_amp_no_bypass) else $error("Amplifier off without bypass");
endmodule : adc_config_regs_zero_one

// file: test/host_cmd_model.sv
// Purpose: Serial-bus engine stand-in issuing register commands
// Assumes: Commands launched at the falling edge
// Notes: Released data lines show the inverse of the last byte
`timescale 1ns/1ps
module host_cmd_model
(
  // Clock
  input wire logic clk_in,
  // Command port
  output logic wr_out,
  output logic rd_out,
  output logic [1:0] addr_out,
  output logic [7:0] data_out
);
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 2'h0;
    data_out = 8'h00;
  end
  // One-cycle strobe, one byte per command
  task automatic cmd(input logic w, input logic [1:0] a, input logic [7:0] d);
  begin
    @(negedge clk_in);
    wr_out = w;
    rd_out = ~w;
    addr_out = a;
    data_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    data_out = ~d;
  end
  endtask : cmd
endmodule : host_cmd_model

// file: test/tb.sv
// Purpose: Self-checking bench for configuration registers zero and one
// Assumes: One-cycle write and read latency
// Notes: Field outputs checked after writes in the amplifier, rate and temperature tests
`timescale 1ns/1ps
module tb;
  logic clk_in, srst_in, power_down_in, wr, rd, rd_valid_out, amp_enable_out, turbo_out, continuous_out, temp_mode_out;
  logic [1:0] addr;
  logic [7:0] wdata, rd_data_out;
  logic [3:0] input_select_field_out;
  logic [2:0] gain_out, rate_select_field_out;
  logic [9:0] mod_clock_khz_out;
  cfg_regs_pkg::ref_src_e ref_src_out;
  int error_cnt = 0;
  int n_compared = 0;
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  host_cmd_model host_cmd_model_inst (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr), .data_out(wdata));
  adc_config_regs_zero_one adc_config_regs_zero_one_inst (.clk_in(clk_in), .srst_in(srst_in),
    .register_write_command_in(wr), .register_read_command_in(rd), .reg_addr_in(addr), .wr_data_in(wdata),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .power_down_in(power_down_in),
    .input_select_field_out(input_select_field_out), .gain_out(gain_out), .amp_enable_out(amp_enable_out),
    .rate_select_field_out(rate_select_field_out), .turbo_out(turbo_out), .mod_clock_khz_out(mod_clock_khz_out),
    .continuous_out(continuous_out), .ref_src_out(ref_src_out), .temp_mode_out(temp_mode_out));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask : chk
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
  begin
    host_cmd_model_inst.cmd(1'b0, a, 8'h00);
    chk(rd_valid_out, 1'b1);
    chk(rd_data_out, exp);
    @(negedge clk_in);
    chk(rd_valid_out, 1'b0);
    chk(rd_data_out, exp);
  end
  endtask : rd_chk
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
  begin
    host_cmd_model_inst.cmd(1'b1, a, d);
  end
  endtask : wr_reg
  task automatic conclude;
  begin
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask : conclude
  task automatic test_reset;
  begin
    chk(amp_enable_out, 1'b1);
    chk(mod_clock_khz_out, 10'(cfg_regs_pkg::MOD_KHZ_NORMAL));
    chk(ref_src_out, cfg_regs_pkg::REF_INTERNAL);
    chk(rd_valid_out, 1'b0);
    rd_chk(cfg_regs_pkg::ADDR_INPUT_GAIN, cfg_regs_pkg::RESET_INPUT_GAIN);
    rd_chk(cfg_regs_pkg::ADDR_RATE_MODE, cfg_regs_pkg::RESET_RATE_MODE);
    $display("reset test done");
  end
  endtask : test_reset
  task automatic test_amp;
  begin
    wr_reg(2'h0, 8'hA5);
    chk(gain_out, 3'h2);
    chk(amp_enable_out, 1'b0);
    wr_reg(2'h0, 8'h37);
    chk(amp_enable_out, 1'b1);
    rd_chk(2'h0, 8'h37);
    $display("amplifier test done");
  end
  endtask : test_amp
  task automatic test_rate;
  begin
    wr_reg(2'h1, 8'h9C);
    chk(rate_select_field_out, 3'h4);
    chk(turbo_out, 1'b1);
    chk(mod_clock_khz_out, 10'(cfg_regs_pkg::MOD_KHZ_TURBO));
    chk(continuous_out, 1'b1);
    chk(ref_src_out, cfg_regs_pkg::REF_SUPPLY);
    wr_reg(2'h1, 8'h62);
    chk(mod_clock_khz_out, 10'(cfg_regs_pkg::MOD_KHZ_NORMAL));
    chk(continuous_out, 1'b0);
    chk(ref_src_out, cfg_regs_pkg::REF_EXTERNAL);
    rd_chk(2'h1, 8'h62);
    $display("rate mode test done");
  end
  endtask : test_rate
  task automatic test_temp;
  begin
    wr_reg(2'h0, 8'hA5);
    wr_reg(2'h1, 8'h07);
    chk(temp_mode_out, 1'b1);
    chk({input_select_field_out, gain_out, amp_enable_out}, 8'h01);
    chk(ref_src_out, cfg_regs_pkg::REF_INTERNAL);
    wr_reg(2'h1, 8'h06);
    chk(temp_mode_out, 1'b0);
    chk(input_select_field_out, 4'hA);
    $display("temperature test done");
  end
  endtask : test_temp
  task automatic test_unmapped_pd;
  begin
    power_down_in = 1'b1;
    wr_reg(2'h3, 8'hFF);
    rd_chk(2'h2, 8'h00);
    rd_chk(2'h0, 8'hA5);
    rd_chk(2'h1, 8'h06);
    power_down_in = 1'b0;
    $display("unmapped and power-down test done");
  end
  endtask : test_unmapped_pd
  task automatic test_midrun_reset;
  begin
    wr_reg(2'h0, 8'h5E);
    wr_reg(2'h1, 8'hB9);
    rd_chk(2'h1, 8'hB9);
    srst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    chk(rd_valid_out, 1'b0);
    chk(rd_data_out, 8'h00);
    chk(temp_mode_out, 1'b0);
    chk(continuous_out, 1'b0);
    chk(mod_clock_khz_out, 10'(cfg_regs_pkg::MOD_KHZ_NORMAL));
    rd_chk(cfg_regs_pkg::ADDR_INPUT_GAIN, cfg_regs_pkg::RESET_INPUT_GAIN);
    rd_chk(cfg_regs_pkg::ADDR_RATE_MODE, cfg_regs_pkg::RESET_RATE_MODE);
    $display("mid-run reset test done");
  end
  endtask : test_midrun_reset
  initial
  begin
    srst_in = 1'b1;
    power_down_in = 1'b0;
    repeat (16) @(negedge clk_in);
    srst_in = 1'b0;
    test_reset();
    test_amp();
    test_rate();
    test_temp();
    test_unmapped_pd();
    test_midrun_reset();
    conclude();
  end
endmodule : tb
